// ===== rtl/cdw_cfg.svh
// constants for the complementary dead-band waveform block
//------------------------------------------------------------------------------
// Overview of operation
// - dead-band clock: system or 16 MHz oscillator
// - two-bit select picks one of four sources
// - both drives cleared right after enable
// - per-output enable; cleared means pin released
// - module disabled: enables and levels ignored
// - polarity set means active-high output
// - polarity never inverts override levels
// - separate 6-bit rising and falling delays, one shared counter
// - count up from zero to delay value
// - rise: B off, delay, then A on
// - fall: A off, delay, then B on
// - delay 0 to 63; zero means none
// - early reversal never turns waiting output on
// - at most one dead-band clock uncertainty
// - software shutdown bit forces override levels
// - no auto-restart: shutdown while bit set
// - auto-restart clears bit, resumes on rise
// - enabled fault inputs force override levels
// - shutdown inputs level-sensitive, hold shutdown state
// - runs in sleep; keeps oscillator when needed
// - override level bit equals pin level
// - software clear needs all selected inputs low
//------------------------------------------------------------------------------
`ifndef CDW_CFG_SVH
`define CDW_CFG_SVH

// register byte offsets
`define CDW_OFS_OUTPUT_CONTROL 12'h000
`define CDW_OFS_SOURCE_SELECT 12'h004
`define CDW_OFS_SHUTDOWN_CONTROL 12'h008
`define CDW_OFS_RISE_DEADBAND 12'h00C
`define CDW_OFS_FALL_DEADBAND 12'h010

// output_control_reg fields
`define CDW_BIT_MODULE_ENABLE 7
`define CDW_BIT_SIDE_B_OE 6
`define CDW_BIT_SIDE_A_OE 5
`define CDW_BIT_SIDE_B_POL 4
`define CDW_BIT_SIDE_A_POL 3
`define CDW_BIT_CLOCK_SELECT 0
// source_select_reg fields
`define CDW_BIT_SIDE_B_OVR 7
`define CDW_BIT_SIDE_A_OVR 5
`define CDW_SRC_SEL_HI 1
`define CDW_SRC_SEL_LO 0
// writable bits; the rest read as zero
`define CDW_MASK_OUTPUT_CONTROL 8'hF9
`define CDW_MASK_SOURCE_SELECT 8'hA3
// shutdown_control_reg fields
`define CDW_BIT_SHUTDOWN_EVENT 7
`define CDW_BIT_AUTO_RESTART 6
`define CDW_BIT_SD_FAULT_PIN 1
`define CDW_BIT_SD_LOGIC_CELL 0

// reset values
`define CDW_RST_BYTE 8'h00
`define CDW_RST_WORD 32'h0000_0000

// clocks
`define CDW_PCLK_MHZ 20
`define CDW_FAST_OSC_MHZ 16

`endif

// ===== rtl/cdw_pkg.sv
// types shared by the complementary dead-band waveform block
package cdw_pkg;

  // phase of the complementary pair
  typedef enum logic [2:0]
  {
    PH_OFF = 3'b000,   // both drives cleared
    PH_RISE = 3'b001,  // dead band before side A turns on
    PH_A_ON = 3'b010,  // side A active
    PH_FALL = 3'b011,  // dead band before side B turns on
    PH_B_ON = 3'b100   // side B active
  } cdw_phase_e;

  // source selection codes
  typedef enum logic [1:0]
  {
    SRC_PWM_ONE = 2'b00,
    SRC_PWM_TWO = 2'b01,
    SRC_OSC_OUT = 2'b10,
    SRC_LOGIC_CELL = 2'b11
  } cdw_source_e;

endpackage : cdw_pkg

// ===== rtl/cdw_top.sv
// complementary dead-band waveform generator with apb registers
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "cdw_cfg.svh"

module cdw_top
#(
  parameter int DB_WIDTH = 6,  // dead-band counter width
  parameter int ADDR_WIDTH = 12
)
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // waveform sources, asynchronous
  input wire logic pwm_channel_one,
  input wire logic pwm_channel_two,
  input wire logic oscillator_output,
  input wire logic logic_cell_output,
  // fault pin and dead-band oscillator, asynchronous
  input wire logic fault_pin,
  input wire logic internal_fast_oscillator,
  // output pins, enables active low
  output logic side_a_output,
  output logic side_a_output_oe_n,
  output logic side_b_output,
  output logic side_b_output_oe_n,
  // sleep support
  output logic fast_osc_keep_alive
);

  //----------------------------------------------------------------------------
  // functions
  //----------------------------------------------------------------------------

  // active level to pin level; set polarity means active-high
  function automatic logic apply_pol(input logic on, input logic pol);
    apply_pol = pol ? on : ~on;
  endfunction : apply_pol

  //----------------------------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------------------------

  localparam int NSYNC = 6;
  logic [NSYNC-1:0] raw_in; // pins as they arrive
  logic [NSYNC-1:0] sync1_ff; // first stage, read only by second stage
  logic [NSYNC-1:0] sync2_ff; // safe to use

  assign raw_in = {internal_fast_oscillator, fault_pin, logic_cell_output,
                   oscillator_output, pwm_channel_two, pwm_channel_one};

  // two-flop synchroniser for every pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  //----------------------------------------------------------------------------
  // register file state
  //----------------------------------------------------------------------------

  logic [7:0] out_ctrl_ff; // output_control_reg
  logic [7:0] src_sel_ff; // source_select_reg
  logic sd_event_ff; // shutdown_event
  logic auto_restart_ff; // auto_restart_enable
  logic sd_lc_en_ff; // shutdown_src_logic_cell_en
  logic sd_fp_en_ff; // shutdown_src_fault_pin_en
  logic [DB_WIDTH-1:0] rise_db_ff; // rise_deadband_count
  logic [DB_WIDTH-1:0] fall_db_ff; // fall_deadband_count
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [7:0] nxt_out_ctrl;
  logic [7:0] nxt_src_sel;
  logic nxt_sd_event;
  logic nxt_auto_restart;
  logic nxt_sd_lc_en;
  logic nxt_sd_fp_en;
  logic [DB_WIDTH-1:0] nxt_rise_db;
  logic [DB_WIDTH-1:0] nxt_fall_db;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  // decoded controls
  logic module_enable;
  logic side_a_output_enable;
  logic side_b_output_enable;
  logic side_a_polarity;
  logic side_b_polarity;
  logic deadband_clock_select;
  logic side_a_override_level;
  logic side_b_override_level;
  logic [1:0] source_select;

  assign module_enable = out_ctrl_ff[`CDW_BIT_MODULE_ENABLE];
  assign side_a_output_enable = out_ctrl_ff[`CDW_BIT_SIDE_A_OE];
  assign side_b_output_enable = out_ctrl_ff[`CDW_BIT_SIDE_B_OE];
  assign side_a_polarity = out_ctrl_ff[`CDW_BIT_SIDE_A_POL];
  assign side_b_polarity = out_ctrl_ff[`CDW_BIT_SIDE_B_POL];
  assign deadband_clock_select = out_ctrl_ff[`CDW_BIT_CLOCK_SELECT];
  assign side_a_override_level = src_sel_ff[`CDW_BIT_SIDE_A_OVR];
  assign side_b_override_level = src_sel_ff[`CDW_BIT_SIDE_B_OVR];
  assign source_select = src_sel_ff[`CDW_SRC_SEL_HI:`CDW_SRC_SEL_LO];

  //----------------------------------------------------------------------------
  // source selection, edges and shutdown inputs
  //----------------------------------------------------------------------------

  logic src_sel; // chosen waveform, synchronised
  logic src_q_ff; // previous source level
  logic src_rise;
  logic src_fall;
  logic ext_sd; // any enabled shutdown input high
  logic osc_q_ff; // previous oscillator level
  logic db_tick; // one dead-band clock period elapsed

  // four-way source mux
  always_comb
  begin
    unique case (cdw_pkg::cdw_source_e'(source_select))
      cdw_pkg::SRC_PWM_ONE: src_sel = sync2_ff[0];
      cdw_pkg::SRC_PWM_TWO: src_sel = sync2_ff[1];
      cdw_pkg::SRC_OSC_OUT: src_sel = sync2_ff[2];
      cdw_pkg::SRC_LOGIC_CELL: src_sel = sync2_ff[3];
    endcase
  end

  assign src_rise = src_sel & ~src_q_ff;
  assign src_fall = ~src_sel & src_q_ff;
  // level-sensitive: held for as long as the input stays high
  assign ext_sd = (sd_lc_en_ff & sync2_ff[3]) | (sd_fp_en_ff & sync2_ff[4]);
  // oscillator edges pace the shared counter when selected, else every pclk
  assign db_tick = deadband_clock_select ? (sync2_ff[5] & ~osc_q_ff) : 1'b1;

  // edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_q_ff <= 1'b0;
      osc_q_ff <= 1'b0;
    end
    else
    begin
      src_q_ff <= src_sel;
      osc_q_ff <= sync2_ff[5];
    end
  end

  //----------------------------------------------------------------------------
  // apb slave
  //----------------------------------------------------------------------------

  logic setup_ph; // first cycle of a transfer
  logic wr_acc; // write taking effect this edge
  logic hit_ctrl;
  logic hit_src;
  logic hit_sd;
  logic hit_rise;
  logic hit_fall;
  logic hit_any;

  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign hit_ctrl = (paddr == `CDW_OFS_OUTPUT_CONTROL);
  assign hit_src = (paddr == `CDW_OFS_SOURCE_SELECT);
  assign hit_sd = (paddr == `CDW_OFS_SHUTDOWN_CONTROL);
  assign hit_rise = (paddr == `CDW_OFS_RISE_DEADBAND);
  assign hit_fall = (paddr == `CDW_OFS_FALL_DEADBAND);
  assign hit_any = hit_ctrl | hit_src | hit_sd | hit_rise | hit_fall;
  // zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  logic resume; // shutdown released on this rising source edge

  // next register values, including hardware updates of the event bit
  always_comb
  begin
    nxt_out_ctrl = out_ctrl_ff;
    nxt_src_sel = src_sel_ff;
    nxt_sd_event = sd_event_ff;
    nxt_auto_restart = auto_restart_ff;
    nxt_sd_lc_en = sd_lc_en_ff;
    nxt_sd_fp_en = sd_fp_en_ff;
    nxt_rise_db = rise_db_ff;
    nxt_fall_db = fall_db_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (wr_acc)
    begin
      if (hit_ctrl)
        nxt_out_ctrl = pwdata[7:0] & `CDW_MASK_OUTPUT_CONTROL; // bits 2-1 unimplemented
      if (hit_src)
        nxt_src_sel = pwdata[7:0] & `CDW_MASK_SOURCE_SELECT;
      if (hit_sd)
      begin
        nxt_auto_restart = pwdata[`CDW_BIT_AUTO_RESTART];
        nxt_sd_fp_en = pwdata[`CDW_BIT_SD_FAULT_PIN];
        nxt_sd_lc_en = pwdata[`CDW_BIT_SD_LOGIC_CELL];
        // a clear only sticks while no selected input is high
        nxt_sd_event = pwdata[`CDW_BIT_SHUTDOWN_EVENT] | ext_sd;
      end
      if (hit_rise)
        nxt_rise_db = pwdata[DB_WIDTH-1:0];
      if (hit_fall)
        nxt_fall_db = pwdata[DB_WIDTH-1:0];
    end
    // auto-restart drops the event once the inputs are quiet
    if (auto_restart_ff && !ext_sd && !(wr_acc && hit_sd))
      nxt_sd_event = 1'b0;
    // hardware set wins over any clear in the same cycle
    if (ext_sd)
      nxt_sd_event = 1'b1;
    if (setup_ph)
    begin
      nxt_pslverr = ~hit_any;
      nxt_prdata = `CDW_RST_WORD;
      if (hit_ctrl)
        nxt_prdata[7:0] = out_ctrl_ff;
      if (hit_src)
        nxt_prdata[7:0] = src_sel_ff;
      if (hit_sd)
      begin
        nxt_prdata[`CDW_BIT_SHUTDOWN_EVENT] = sd_event_ff;
        nxt_prdata[`CDW_BIT_AUTO_RESTART] = auto_restart_ff;
        nxt_prdata[`CDW_BIT_SD_FAULT_PIN] = sd_fp_en_ff;
        nxt_prdata[`CDW_BIT_SD_LOGIC_CELL] = sd_lc_en_ff;
      end
      if (hit_rise)
        nxt_prdata[DB_WIDTH-1:0] = rise_db_ff;
      if (hit_fall)
        nxt_prdata[DB_WIDTH-1:0] = fall_db_ff;
    end
  end

  // register file flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_ctrl_ff <= `CDW_RST_BYTE;
      src_sel_ff <= `CDW_RST_BYTE;
      sd_event_ff <= 1'b0;
      auto_restart_ff <= 1'b0;
      sd_lc_en_ff <= 1'b0;
      sd_fp_en_ff <= 1'b0;
      rise_db_ff <= '0;
      fall_db_ff <= '0;
      prdata_ff <= `CDW_RST_WORD;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      out_ctrl_ff <= nxt_out_ctrl;
      src_sel_ff <= nxt_src_sel;
      sd_event_ff <= nxt_sd_event;
      auto_restart_ff <= nxt_auto_restart;
      sd_lc_en_ff <= nxt_sd_lc_en;
      sd_fp_en_ff <= nxt_sd_fp_en;
      rise_db_ff <= nxt_rise_db;
      fall_db_ff <= nxt_fall_db;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  //----------------------------------------------------------------------------
  // shutdown hold and dead-band phase machine
  //----------------------------------------------------------------------------

  cdw_pkg::cdw_phase_e phase_ff;
  cdw_pkg::cdw_phase_e nxt_phase;
  logic [DB_WIDTH-1:0] cnt_ff; // shared dead-band count
  logic [DB_WIDTH-1:0] nxt_cnt;
  logic [DB_WIDTH-1:0] cnt_inc;
  logic sd_hold_ff; // stays in shutdown until a rising source edge
  logic nxt_sd_hold;
  logic in_shutdown;

  assign cnt_inc = cnt_ff + 1'b1;
  // outputs keep override levels until the first rise after the event clears
  assign resume = src_rise & ~sd_event_ff & ~ext_sd;
  assign in_shutdown = sd_event_ff | ext_sd | (sd_hold_ff & ~resume);

  // next phase and count
  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_sd_hold = sd_hold_ff;
    if (sd_event_ff || ext_sd)
      nxt_sd_hold = 1'b1;
    else if (resume)
      nxt_sd_hold = 1'b0;
    if (!module_enable || in_shutdown)
    begin
      nxt_phase = cdw_pkg::PH_OFF;
      nxt_cnt = '0;
    end
    else if (src_rise)
    begin
      // side B drops now; a zero delay turns A on at once
      nxt_cnt = '0;
      nxt_phase = (rise_db_ff == '0) ? cdw_pkg::PH_A_ON : cdw_pkg::PH_RISE;
    end
    else if (src_fall)
    begin
      // a reversal mid-count abandons the waiting side
      nxt_cnt = '0;
      nxt_phase = (fall_db_ff == '0) ? cdw_pkg::PH_B_ON : cdw_pkg::PH_FALL;
    end
    else
    begin
      unique case (phase_ff)
        cdw_pkg::PH_RISE:
          if (db_tick)
          begin
            nxt_cnt = cnt_inc;
            if (cnt_inc == rise_db_ff)
              nxt_phase = cdw_pkg::PH_A_ON;
          end
        cdw_pkg::PH_FALL:
          if (db_tick)
          begin
            nxt_cnt = cnt_inc;
            if (cnt_inc == fall_db_ff)
              nxt_phase = cdw_pkg::PH_B_ON;
          end
        cdw_pkg::PH_OFF, cdw_pkg::PH_A_ON, cdw_pkg::PH_B_ON:
          nxt_cnt = cnt_ff;
        default:
          nxt_phase = cdw_pkg::PH_OFF;
      endcase
    end
  end

  // phase flops; source edge is sampled on pclk, hence one tick of slack
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_ff <= cdw_pkg::PH_OFF;
      cnt_ff <= '0;
      sd_hold_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      sd_hold_ff <= nxt_sd_hold;
    end
  end

  //----------------------------------------------------------------------------
  // pin drive
  //----------------------------------------------------------------------------

  logic a_ff;
  logic a_oe_n_ff;
  logic b_ff;
  logic b_oe_n_ff;
  logic keep_ff;
  logic nxt_a;
  logic nxt_a_oe_n;
  logic nxt_b;
  logic nxt_b_oe_n;
  logic nxt_keep;

  // levels: override in shutdown, else polarity-adjusted waveform
  always_comb
  begin
    if (in_shutdown)
    begin
      nxt_a = side_a_override_level;
      nxt_b = side_b_override_level;
    end
    else
    begin
      nxt_a = apply_pol(nxt_phase == cdw_pkg::PH_A_ON, side_a_polarity);
      nxt_b = apply_pol(nxt_phase == cdw_pkg::PH_B_ON, side_b_polarity);
    end
    // disabled module releases both pins whatever the enables say
    nxt_a_oe_n = ~(module_enable & side_a_output_enable);
    nxt_b_oe_n = ~(module_enable & side_b_output_enable);
    // oscillator must stay up in sleep while it paces a live waveform
    nxt_keep = module_enable & deadband_clock_select & (src_sel | src_q_ff | (phase_ff != cdw_pkg::PH_OFF));
  end

  // output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_ff <= 1'b0;
      a_oe_n_ff <= 1'b1;
      b_ff <= 1'b0;
      b_oe_n_ff <= 1'b1;
      keep_ff <= 1'b0;
    end
    else
    begin
      a_ff <= nxt_a;
      a_oe_n_ff <= nxt_a_oe_n;
      b_ff <= nxt_b;
      b_oe_n_ff <= nxt_b_oe_n;
      keep_ff <= nxt_keep;
    end
  end

  assign side_a_output = a_ff;
  assign side_a_output_oe_n = a_oe_n_ff;
  assign side_b_output = b_ff;
  assign side_b_output_oe_n = b_oe_n_ff;
  assign fast_osc_keep_alive = keep_ff;

endmodule : cdw_top

// ===== verif/cdw_sva.sv
// port checker for the complementary dead-band waveform block
`timescale 1ns/1ps
module cdw_sva
#(
  parameter int DB_WIDTH = 6,
  parameter int ADDR_WIDTH = 12
)
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic fault_pin,
  input wire logic side_a_output,
  input wire logic side_a_output_oe_n,
  input wire logic side_b_output,
  input wire logic side_b_output_oe_n,
  input wire logic fast_osc_keep_alive
);
  // -------------------------------------------------
  // shadow control bytes, tracked from apb writes
  // -------------------------------------------------
  logic [7:0] ctl_ff;  // output control copy
  logic [7:0] ovr_ff;  // source select and override copy
  logic [7:0] sd_ff;   // shutdown control copy; event bit may differ
  logic bad;           // address outside the register map
  assign bad = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010});
  // copies update on the same access edge as the real registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_ff <= 8'h00;
      ovr_ff <= 8'h00;
      sd_ff <= 8'h00;
    end
    else if (psel && penable && pwrite)
    begin
      case (paddr)
        12'h000: ctl_ff <= pwdata[7:0];
        12'h004: ovr_ff <= pwdata[7:0];
        12'h008: sd_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_off_release: assert property (!ctl_ff[7] && $past(!ctl_ff[7]) |-> side_a_output_oe_n && side_b_output_oe_n)
    else $error("pin driven while module disabled");
  chk_a_drive: assert property (ctl_ff[7] && ctl_ff[5] && $past(ctl_ff[7] && ctl_ff[5]) |-> !side_a_output_oe_n)
    else $error("side a not driven");
  chk_b_release: assert property (ctl_ff[7] && !ctl_ff[6] && $past(ctl_ff[7] && !ctl_ff[6])
    |-> side_b_output_oe_n)
    else $error("side b driven while disabled");
  // overlap only judged with both sides active high and no double-high override
  chk_no_overlap: assert property ($past(ctl_ff[4:3]) == 2'b11 && ctl_ff[4:3] == 2'b11
    && !(ovr_ff[7] && ovr_ff[5]) |-> !(side_a_output && side_b_output))
    else $error("both sides active");
  chk_keep_alive: assert property (!(ctl_ff[7] && ctl_ff[0]) [*3] |-> !fast_osc_keep_alive)
    else $error("oscillator held without need");
  chk_fault_a: assert property ((ctl_ff[7] && sd_ff[1] && fault_pin && $stable(ovr_ff)) [*5]
    |-> side_a_output == ovr_ff[5])
    else $error("side a not at override level");
  chk_fault_b: assert property ((ctl_ff[7] && sd_ff[1] && fault_pin && $stable(ovr_ff)) [*5]
    |-> side_b_output == ovr_ff[7])
    else $error("side b not at override level");
  chk_err_unmapped: assert property (psel && penable && bad |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (psel && penable && !bad |-> !pslverr && prdata[31:8] == 24'h00_0000)
    else $error("mapped access flagged or wide");
  cov_fault: cover property (fault_pin && sd_ff[1] && side_b_output);
  cov_unmapped: cover property (psel && penable && pslverr);
  cov_keep: cover property (fast_osc_keep_alive);
endmodule : cdw_sva

bind cdw_top cdw_sva #(.DB_WIDTH(DB_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) cdw_sva_inst
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_pin(fault_pin),
  .side_a_output(side_a_output), .side_a_output_oe_n(side_a_output_oe_n), .side_b_output(side_b_output),
  .side_b_output_oe_n(side_b_output_oe_n), .fast_osc_keep_alive(fast_osc_keep_alive)
);

// ===== verif/cdw_gate_model.sv
// gate driver model loading the two output pins
`timescale 1ns/1ps
module cdw_gate_model
(
  // pins from the block
  input wire logic pin_a,
  input wire logic oe_n_a,
  input wire logic pin_b,
  input wire logic oe_n_b,
  // levels seen at the switch gates
  output logic gate_a,
  output logic gate_b
);
  // a released pin falls to the driver input pull-down, never keeps its last level
  assign gate_a = oe_n_a ? 1'b0 : pin_a;
  assign gate_b = oe_n_b ? 1'b0 : pin_b;
endmodule : cdw_gate_model

// ===== verif/tb_top.sv
// self-checking bench for the complementary dead-band waveform block
`timescale 1ns/1ps
`include "cdw_cfg.svh"
module tb_top;
  // ----------------------------------------
  // stimulus, pins and bookkeeping
  // ----------------------------------------
  localparam logic [11:0] CTL = `CDW_OFS_OUTPUT_CONTROL;
  localparam logic [11:0] SEL = `CDW_OFS_SOURCE_SELECT;
  localparam logic [11:0] SD = `CDW_OFS_SHUTDOWN_CONTROL;
  localparam logic [11:0] RISE = `CDW_OFS_RISE_DEADBAND;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, a, a_oe_n, b, b_oe_n, keep, gate_a, gate_b;
  logic [3:0] src = 4'h0;  // pwm one, pwm two, osc out, logic cell
  logic fault_pin = 1'b0;
  logic fosc = 1'b0;       // oscillator stand-in, kept below pclk/2 so it never aliases
  logic osc_run = 1'b0;
  logic ph = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  always #25 pclk = ~pclk;
  // oscillator toggles every second pclk edge while a test wants it
  always @(posedge pclk)
  begin
    ph <= ~ph;
    if (ph)
      fosc <= osc_run & ~fosc;
  end
  cdw_top cdw_top_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_channel_one(src[0]),
    .pwm_channel_two(src[1]), .oscillator_output(src[2]), .logic_cell_output(src[3]),
    .fault_pin(fault_pin), .internal_fast_oscillator(fosc), .side_a_output(a), .side_a_output_oe_n(a_oe_n),
    .side_b_output(b), .side_b_output_oe_n(b_oe_n), .fast_osc_keep_alive(keep)
  );
  cdw_gate_model cdw_gate_model_inst
  (
    .pin_a(a), .oe_n_a(a_oe_n), .pin_b(b), .oe_n_b(b_oe_n), .gate_a(gate_a), .gate_b(gate_b)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer held until pready; read data lands in q
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // mid-cycle count until a pin reaches a level
  task automatic wait_pin(input logic sel_b, input logic v);
    while ((sel_b ? b : a) !== v && n < 300)
    begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_pin
  // source edge: losing side drops at once, other side follows after the dead band
  task automatic t_edge(input int s, input logic v, input int lo, input int hi);
    int nb;
    @(posedge pclk);
    src[s] <= v;
    n = 0;
    wait_pin(v, 1'b0);
    nb = n;
    wait_pin(!v, 1'b1);
    chk("turn off", nb <= 4, 1);
    chk("dead band", n >= lo && n <= hi, 1);
  endtask : t_edge
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      chk("reset value", q, 32'h0000_0000);
    end
    chk("pins released", {a_oe_n, b_oe_n, gate_a, gate_b}, 4'b1100);
    apb(1'b1, 12'h014, 32'h0000_00FF);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped read", q, 32'h0000_0000);
    apb(1'b1, CTL, 32'h0000_007F);
    apb(1'b0, CTL, 32'h0000_0000);
    chk("reserved bits", q, 32'h0000_0079);
  endtask : t_reset
  // configure in order, start from shutdown, then release by clearing the event
  task automatic t_start(input logic [31:0] sel);
    apb(1'b1, CTL, 32'h0000_0000);
    apb(1'b1, RISE, 32'h0000_0002);
    apb(1'b1, `CDW_OFS_FALL_DEADBAND, 32'h0000_0003);
    apb(1'b1, SD, 32'h0000_0080);
    apb(1'b1, SEL, sel);
    apb(1'b1, CTL, 32'h0000_0078);
    apb(1'b1, CTL, 32'h0000_00F8);
    repeat (3) @(negedge pclk);
    chk("both cleared", {a, b, a_oe_n, b_oe_n}, 4'b0000);
    apb(1'b1, SD, 32'h0000_0000);
  endtask : t_start
  task automatic t_sources;
    for (int s = 0; s < 4; s++)
    begin
      t_start(32'(s));
      t_edge(s, 1'b1, 5, 7);
      t_edge(s, 1'b0, 6, 8);
    end
  endtask : t_sources
  // zero dead band, then a pulse shorter than the rise count
  task automatic t_short;
    apb(1'b1, RISE, 32'h0000_0000);
    t_edge(3, 1'b1, 3, 5);
    t_edge(3, 1'b0, 6, 8);
    apb(1'b1, RISE, 32'h0000_0014);
    @(posedge pclk);
    src[3] <= 1'b1;
    repeat (6) @(posedge pclk);
    src[3] <= 1'b0;
    n = 0;
    repeat (40) @(negedge pclk) n += int'(a === 1'b1);
    chk("aborted turn on", n, 0);
  endtask : t_short
  task automatic t_soft_sd;
    apb(1'b1, CTL, 32'h0000_00F0);
    repeat (3) @(negedge pclk);
    chk("active low idle", {a, b}, 2'b11);
    apb(1'b1, SEL, 32'h0000_0083);
    apb(1'b1, SD, 32'h0000_0080);
    repeat (4) @(negedge pclk);
    chk("sw override", {a, b}, 2'b01);
    @(posedge pclk);
    src[3] <= 1'b1;
    repeat (30) @(negedge pclk);
    chk("held", {a, b}, 2'b01);
    apb(1'b1, CTL, 32'h0000_00F8);
    apb(1'b1, SD, 32'h0000_0000);
    repeat (4) @(negedge pclk);
    chk("wait for rise", {a, b}, 2'b01);
    @(posedge pclk);
    src[3] <= 1'b0;
    repeat (4) @(negedge pclk);
    t_edge(3, 1'b1, 23, 25);
  endtask : t_soft_sd
  task automatic t_fault;
    apb(1'b1, SD, 32'h0000_0002);
    fault_pin <= 1'b1;
    repeat (5) @(negedge pclk);
    chk("fault override", {a, b}, 2'b01);
    apb(1'b1, SD, 32'h0000_0002);
    apb(1'b0, SD, 32'h0000_0000);
    chk("event held", q[7], 1'b1);
    fault_pin <= 1'b0;
    src[3] <= 1'b0;
    apb(1'b1, SD, 32'h0000_00C2);
    repeat (4) @(negedge pclk);
    apb(1'b0, SD, 32'h0000_0000);
    chk("auto clear", q[7], 1'b0);
    t_edge(3, 1'b1, 23, 25);
    apb(1'b1, SD, 32'h0000_0001);
    repeat (5) @(negedge pclk);
    chk("logic cell override", {a, b}, 2'b01);
    @(posedge pclk);
    src[3] <= 1'b0;
    apb(1'b1, SD, 32'h0000_0000);
  endtask : t_fault
  // dead band ticks from the oscillator, four pclk each
  task automatic t_osc;
    osc_run <= 1'b1;
    apb(1'b1, RISE, 32'h0000_0002);
    apb(1'b1, CTL, 32'h0000_00F9);
    t_edge(3, 1'b1, 7, 16);
    chk("keep alive", keep, 1'b1);
    osc_run <= 1'b0;
  endtask : t_osc
  task automatic t_enables;
    apb(1'b1, CTL, 32'h0000_00D8);
    repeat (3) @(negedge pclk);
    chk("a released", {a_oe_n, b_oe_n, gate_a}, 3'b100);
    apb(1'b1, CTL, 32'h0000_00B8);
    repeat (3) @(negedge pclk);
    chk("b released", {a_oe_n, b_oe_n, gate_a, gate_b}, 4'b0110);
    apb(1'b1, CTL, 32'h0000_0078);
    repeat (3) @(negedge pclk);
    chk("module off", {a_oe_n, b_oe_n}, 2'b11);
  endtask : t_enables
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // watchdog: about forty times the expected run
  initial
  begin
    #1_000_000;
    n_mismatch++;
    summarize;
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_sources;
    t_short;
    t_soft_sd;
    t_fault;
    t_osc;
    t_enables;
    summarize;
  end
endmodule : tb_top
